// ===== hdl/boundary_scan_test_port.sv
/*
 Boundary-scan test access port with its pin muxing, plus the FIFO that carries
 updated boundary-cell values from the test-clock domain to the system clock.
 Assumes: tck is a free test clock of its own, trst_n resets it asynchronously,
 pads are resolved outside from pad_out/pad_oe, core logic runs on clk.
*/
`timescale 1ns/1ps
`include "scan_port_regs.svh"

// ------------------------------------------------------------
// Synchronous FIFO
// ------------------------------------------------------------
module scan_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage needs no reset; only what the pointers cover is ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule : scan_fifo

// ------------------------------------------------------------
// Test port top
// ------------------------------------------------------------
// Function
// - EXTEST: scan chain in path, cells drive outputs
// - BYPASS: only bypass stage in path
// - IDCODE: load identification value, put in path
// - HIGHZ: bypass in path, all outputs released
// - CLAMP: cells drive outputs, bypass in path
// - SAMPLE: scan chain captures live pin values
// - PRELOAD: shift into cells without disturbing pins
// - Identification: revision, part code, vendor code
// - Identification bit zero always one
// - Forcing and release never touch test output
// - Sampling excludes the four test inputs
// - Test port runs at any tck rate, not fixed at 10MHz
module boundary_scan_test_port #(
   parameter int N_IN = 4,
   parameter int N_OUT = 4,
   parameter logic [3:0] ID_REVISION = 4'h1,       // Arbitrary value
   parameter logic [15:0] ID_PART = 16'h5a5a,      // Arbitrary value
   parameter logic [10:0] ID_VENDOR = 11'h2aa      // Arbitrary value
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   output logic tdo,
   output logic tdo_oe,
   input wire logic [N_OUT-1:0] core_out,
   input wire logic core_oe,
   output logic [N_IN-1:0] core_in,
   input wire logic [N_IN-1:0] pad_in,
   output logic [N_OUT-1:0] pad_out,
   output logic pad_oe,
   input wire logic apply_ready,
   output logic apply_pending
);
   // Chain order from tdo side: inputs, outputs, then the shared enable cell
   localparam int L = N_IN + N_OUT + 1;
   localparam int UW = N_OUT + 1;
   localparam logic [`ID_WIDTH-1:0] ID_VALUE = {ID_REVISION, ID_PART, ID_VENDOR, `ID_MARKER};

   // ------------------------------------------------------------
   // Test-clock domain
   // ------------------------------------------------------------
   // Runs on tck only, at any rate; the logic never uses TCK_PERIOD_NS
   scan_port_pkg::tap_state_t st_q, st_d;
   logic [`IR_WIDTH-1:0] ir_sh_q, ir_sh_d, instr_q, instr_d;
   logic [`ID_WIDTH-1:0] id_q, id_d;
   logic byp_q, byp_d;
   logic [L-1:0] bsr_q, bsr_d, snap_m_q, snap_q;
   logic [UW-1:0] hold_q, hold_d;
   logic req_q, req_d, ack_m_q, ack_q;
   logic tdo_d, tdo_q, tdo_oe_q;
   logic sel_bsr, sel_id, force_t, highz_t;
   // System-clock state, declared early because the test-clock side samples it
   logic [N_IN-1:0] pad_in_m_q, pad_in_q;
   logic [N_OUT-1:0] pad_out_q, pad_out_d;
   logic pad_oe_q, pad_oe_d;
   logic [1:0] mode_m_q, mode_q;
   logic req_m_q, req_s_q, ack_seen_q, ack_seen_d;
   logic [UW-1:0] force_q, force_d, fifo_out;
   logic push, fifo_in_ready, fifo_out_valid, pop;

   always_comb begin
      sel_bsr = (instr_q == `INSTR_EXTEST) || (instr_q == `INSTR_SAMPLE);
      sel_id = (instr_q == `INSTR_IDCODE);
      // Everything else, reserved codes included, goes through bypass
      force_t = (instr_q == `INSTR_EXTEST) || (instr_q == `INSTR_CLAMP);
      highz_t = (instr_q == `INSTR_HIGHZ);
   end

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         scan_port_pkg::TEST_LOGIC_RESET: st_d = tms ? st_q : scan_port_pkg::RUN_TEST_IDLE;
         scan_port_pkg::RUN_TEST_IDLE: st_d = tms ? scan_port_pkg::SELECT_DR : st_q;
         scan_port_pkg::SELECT_DR: st_d = tms ? scan_port_pkg::SELECT_IR : scan_port_pkg::CAPTURE_DR;
         scan_port_pkg::CAPTURE_DR: st_d = tms ? scan_port_pkg::EXIT1_DR : scan_port_pkg::SHIFT_DR;
         scan_port_pkg::SHIFT_DR: st_d = tms ? scan_port_pkg::EXIT1_DR : st_q;
         scan_port_pkg::EXIT1_DR: st_d = tms ? scan_port_pkg::UPDATE_DR : scan_port_pkg::PAUSE_DR;
         scan_port_pkg::PAUSE_DR: st_d = tms ? scan_port_pkg::EXIT2_DR : st_q;
         scan_port_pkg::EXIT2_DR: st_d = tms ? scan_port_pkg::UPDATE_DR : scan_port_pkg::SHIFT_DR;
         scan_port_pkg::UPDATE_DR: st_d = tms ? scan_port_pkg::SELECT_DR : scan_port_pkg::RUN_TEST_IDLE;
         scan_port_pkg::SELECT_IR: st_d = tms ? scan_port_pkg::TEST_LOGIC_RESET : scan_port_pkg::CAPTURE_IR;
         scan_port_pkg::CAPTURE_IR: st_d = tms ? scan_port_pkg::EXIT1_IR : scan_port_pkg::SHIFT_IR;
         scan_port_pkg::SHIFT_IR: st_d = tms ? scan_port_pkg::EXIT1_IR : st_q;
         scan_port_pkg::EXIT1_IR: st_d = tms ? scan_port_pkg::UPDATE_IR : scan_port_pkg::PAUSE_IR;
         scan_port_pkg::PAUSE_IR: st_d = tms ? scan_port_pkg::EXIT2_IR : st_q;
         scan_port_pkg::EXIT2_IR: st_d = tms ? scan_port_pkg::UPDATE_IR : scan_port_pkg::SHIFT_IR;
         scan_port_pkg::UPDATE_IR: st_d = tms ? scan_port_pkg::SELECT_DR : scan_port_pkg::RUN_TEST_IDLE;
      endcase
   end

   always_comb begin
      ir_sh_d = ir_sh_q;
      instr_d = instr_q;
      id_d = id_q;
      byp_d = byp_q;
      bsr_d = bsr_q;
      hold_d = hold_q;
      req_d = req_q;
      tdo_d = byp_q;
      unique case (st_q)
         scan_port_pkg::TEST_LOGIC_RESET: instr_d = `INSTR_IDCODE;
         scan_port_pkg::CAPTURE_IR: ir_sh_d = `IR_CAPTURE;
         scan_port_pkg::SHIFT_IR: ir_sh_d = {tdi, ir_sh_q[`IR_WIDTH-1:1]};
         scan_port_pkg::UPDATE_IR: instr_d = ir_sh_q;
         scan_port_pkg::CAPTURE_DR: begin
            if (sel_bsr) begin
               bsr_d = snap_q;
            end else if (sel_id) begin
               id_d = ID_VALUE;
            end else begin
               byp_d = `BYPASS_CAPTURE;
            end
         end
         scan_port_pkg::SHIFT_DR: begin
            if (sel_bsr) begin
               bsr_d = {tdi, bsr_q[L-1:1]};
            end else if (sel_id) begin
               id_d = {tdi, id_q[`ID_WIDTH-1:1]};
            end else begin
               byp_d = tdi;
            end
         end
         scan_port_pkg::UPDATE_DR: begin
            // A new update is dropped while the previous one is still crossing
            if (sel_bsr && (req_q == ack_q)) begin
               hold_d = bsr_q[L-1:N_IN];
               req_d = ~req_q;
            end
         end
         default: ;
      endcase
      if (st_q == scan_port_pkg::SHIFT_IR) begin
         tdo_d = ir_sh_q[0];
      end else if (sel_bsr) begin
         tdo_d = bsr_q[0];
      end else if (sel_id) begin
         tdo_d = id_q[0];
      end
   end

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         st_q <= scan_port_pkg::TEST_LOGIC_RESET;
         ir_sh_q <= `IR_CAPTURE;
         instr_q <= `INSTR_IDCODE;
         id_q <= '0;
         byp_q <= 1'b0;
         bsr_q <= '0;
         hold_q <= '0;
         req_q <= 1'b0;
         ack_m_q <= 1'b0;
         ack_q <= 1'b0;
         snap_m_q <= '0;
         snap_q <= '0;
      end else begin
         st_q <= st_d;
         ir_sh_q <= ir_sh_d;
         instr_q <= instr_d;
         id_q <= id_d;
         byp_q <= byp_d;
         bsr_q <= bsr_d;
         hold_q <= hold_d;
         req_q <= req_d;
         ack_m_q <= ack_seen_q;
         ack_q <= ack_m_q;
         snap_m_q <= {pad_oe_q, pad_out_q, pad_in_q};
         snap_q <= snap_m_q;
      end
   end

   // Output moves on the falling edge so the tester samples a settled bit
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         tdo_q <= tdo_d;
         tdo_oe_q <= (st_q == scan_port_pkg::SHIFT_IR) || (st_q == scan_port_pkg::SHIFT_DR);
      end
   end

   assign tdo = tdo_q;
   assign tdo_oe = tdo_oe_q;

   // ------------------------------------------------------------
   // System-clock domain
   // ------------------------------------------------------------
   assign push = (req_s_q != ack_seen_q);
   assign pop = fifo_out_valid && apply_ready;

   always_comb begin
      ack_seen_d = ack_seen_q;
      force_d = force_q;
      // The acknowledge waits while the FIFO is full, so the next update is dropped
      if (push && fifo_in_ready) begin
         ack_seen_d = req_s_q;
      end
      if (pop) begin
         force_d = fifo_out;
      end
      if (mode_q[0]) begin
         pad_out_d = force_q[N_OUT-1:0];
         pad_oe_d = force_q[N_OUT];
      end else begin
         pad_out_d = core_out;
         pad_oe_d = core_oe;
      end
      if (mode_q[1]) begin
         pad_oe_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pad_in_m_q <= '0;
         pad_in_q <= '0;
         pad_out_q <= '0;
         pad_oe_q <= 1'b0;
         mode_m_q <= '0;
         mode_q <= '0;
         req_m_q <= 1'b0;
         req_s_q <= 1'b0;
         ack_seen_q <= 1'b0;
         force_q <= '0;
      end else begin
         pad_in_m_q <= pad_in;
         pad_in_q <= pad_in_m_q;
         pad_out_q <= pad_out_d;
         pad_oe_q <= pad_oe_d;
         mode_m_q <= {highz_t, force_t};
         mode_q <= mode_m_q;
         req_m_q <= req_q;
         req_s_q <= req_m_q;
         ack_seen_q <= ack_seen_d;
         force_q <= force_d;
      end
   end

   assign core_in = pad_in_q;
   assign pad_out = pad_out_q;
   assign pad_oe = pad_oe_q;
   assign apply_pending = fifo_out_valid;

   scan_fifo #(
      .WIDTH(UW),
      .DEPTH(`FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(hold_q),
      .out_valid(fifo_out_valid),
      .out_ready(apply_ready),
      .out_data(fifo_out)
   );
endmodule : boundary_scan_test_port

// ===== hdl/scan_port_regs.svh
/*
 Named constants of the boundary-scan test port: instruction codes, register sizes,
 capture patterns and test-clock timing. Assumes nothing beyond a plain include.
*/
`ifndef SCAN_PORT_REGS_SVH
`define SCAN_PORT_REGS_SVH

// ------------------------------------------------------------
// Instruction register
// ------------------------------------------------------------
`define IR_WIDTH 4
`define INSTR_EXTEST 4'h0
`define INSTR_SAMPLE 4'h1
`define INSTR_IDCODE 4'h2
`define INSTR_CLAMP 4'h3
`define INSTR_HIGHZ 4'h4
`define INSTR_BYPASS 4'hf
`define IR_CAPTURE 4'h1

// ------------------------------------------------------------
// Data registers
// ------------------------------------------------------------
`define ID_WIDTH 32
`define ID_MARKER 1'b1
`define BYPASS_CAPTURE 1'b0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define TCK_PERIOD_NS 100
`define CLK_PERIOD_NS 10
`define TCK_IN_CLK_CYCLES ((`TCK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH 32

`endif

// ===== hdl/scan_port_pkg.sv
/*
 Types of the boundary-scan test port: controller states.
 Assumes the constants header is included by the design file.
*/
package scan_port_pkg;

   typedef enum logic [3:0] {
      TEST_LOGIC_RESET, RUN_TEST_IDLE,
      SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
      SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
   } tap_state_t;

endpackage : scan_port_pkg

// ===== verif/boundary_scan_test_port_chk.sv
/* Pin-level assertions for the boundary-scan test port.
   Assumes the bind below and both resets applied together at start. */
`timescale 1ns/1ps
module boundary_scan_test_port_chk #(
   parameter int N_IN = 4,
   parameter int N_OUT = 4
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic [N_OUT-1:0] core_out,
   input wire logic core_oe,
   input wire logic [N_IN-1:0] core_in,
   input wire logic [N_IN-1:0] pad_in,
   input wire logic [N_OUT-1:0] pad_out,
   input wire logic pad_oe,
   input wire logic apply_ready,
   input wire logic apply_pending
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_trst_clear: assert property (@(posedge clk) disable iff (reset)
      !trst_n && !$past(trst_n) |-> !tdo_oe && !tdo) else $error("tdo active in test reset");
   a_shift_hold: assert property (@(posedge tck) disable iff (!trst_n)
      tdo_oe |=> tdo_oe == !$past(tms)) else $error("shift exit wrong");
   a_shift_entry: assert property (@(posedge tck) disable iff (!trst_n)
      $rose(tdo_oe) |-> !$past(tms)) else $error("shift entered with tms high");
   a_tms_reset: assert property (@(posedge tck) disable iff (!trst_n)
      tms [*5] |=> !tdo_oe) else $error("five tms ones left shift active");
   a_core_sync: assert property (@(posedge clk) disable iff (reset)
      !$past(reset) && !$past(reset, 2) |-> core_in == $past(pad_in, 2)) else $error("core_in lag");
   a_reset_pads: assert property (@(posedge clk) disable iff (reset)
      $past(reset) |-> !pad_oe && pad_out == '0 && !apply_pending) else $error("pins not idle");
   a_no_pop_hold: assert property (@(posedge clk) disable iff (reset)
      apply_pending && !apply_ready |=> apply_pending) else $error("word lost without ready");
   // Pops run at most one a cycle, so a full buffer needs a generous bound
   a_pop_drain: assert property (@(posedge clk) disable iff (reset)
      apply_pending && apply_ready |-> ##[1:80] !apply_pending) else $error("words not drained");
   c_shift: cover property (@(posedge tck) $rose(tdo_oe));
   c_drain: cover property (@(posedge clk) $fell(apply_pending));
   c_release: cover property (@(posedge clk) $fell(pad_oe));
endmodule : boundary_scan_test_port_chk

bind boundary_scan_test_port boundary_scan_test_port_chk #(.N_IN(N_IN), .N_OUT(N_OUT))
   chk_i (.clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
   .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
   .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .apply_ready(apply_ready),
   .apply_pending(apply_pending));

// ===== verif/scan_controller.sv
/* Behavioural test controller driving the scan port pins.
   Assumes the port samples on rising tck and updates tdo on falling tck. */
`timescale 1ns/1ps
module scan_controller (
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n,
   input wire logic tdo
);
   // ----------------------------------------
   // Pin sequencing
   // ----------------------------------------
   // The clock stands still between frames, as a tester's would
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
      trst_n = 1'h0;
   end

   // One 15 ns cycle; tdo is read just before the rising edge
   task automatic tick(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #7.5;
      o = tdo;
      tck = 1'h1;
      #7.5;
      tck = 1'h0;
   endtask : tick

   task automatic reset_tap();
      logic o;
      trst_n = 1'h0;
      #60 trst_n = 1'h1;
      repeat (5) tick(1'h1, 1'h0, o);
      tick(1'h0, 1'h0, o);
   endtask : reset_tap

   // From idle through capture, shift and update back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
         output logic [31:0] dout);
      logic o;
      dout = '0;
      tick(1'h1, 1'h0, o);
      if (ir) begin
         tick(1'h1, 1'h0, o);
      end
      tick(1'h0, 1'h0, o);
      tick(1'h0, 1'h0, o);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], o);
         dout[i] = o;
      end
      tick(1'h1, ~din[n-1], o);
      tick(1'h0, din[n-1], o);
      // Released line must not keep looking like data
      tdi = ~tdi;
   endtask : scan
endmodule : scan_controller

// ===== verif/boundary_scan_test_port_tb_top.sv
/* Self-checking bench for the boundary-scan test port.
   Assumes scan_controller as the tester and the checker bound to the top. */
`timescale 1ns/1ps
`include "scan_port_regs.svh"
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin failures++; \
   $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module boundary_scan_test_port_tb_top;
   localparam logic [3:0] REV = 4'h3; // Arbitrary value
   localparam logic [15:0] PART = 16'hc3c3; // Arbitrary value
   localparam logic [10:0] VEND = 11'h155; // Arbitrary value
   logic clk, reset, tck, tms, tdi, trst_n, tdo, tdo_oe, core_oe, pad_oe;
   logic apply_ready, apply_pending;
   logic [3:0] core_out, core_in, pad_in, pad_out;
   logic [31:0] dout;
   int failures = 0;
   int total_checks = 0;

   boundary_scan_test_port #(.ID_REVISION(REV), .ID_PART(PART), .ID_VENDOR(VEND)) dut (
      .clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
      .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .apply_ready(apply_ready),
      .apply_pending(apply_pending));
   scan_controller ctl (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   task automatic end_sim();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   // Mode crosses to clk in a few cycles, so settle before looking at pins
   task automatic set_ir(input logic [3:0] code);
      ctl.scan(1'h1, 4, {28'h0, code}, dout);
      `CHK("ir capture", 4'h1, dout[3:0])
      repeat (10) @(negedge clk);
   endtask : set_ir

   task automatic t_idcode();
      set_ir(`INSTR_IDCODE);
      ctl.scan(1'h0, 32, 32'h0, dout);
      `CHK("id value", {REV, PART, VEND, 1'h1}, dout)
      $display("idcode test done");
   endtask : t_idcode

   task automatic t_bypass();
      logic [3:0] codes [2] = '{`INSTR_BYPASS, `INSTR_HIGHZ};
      foreach (codes[k]) begin
         set_ir(codes[k]);
         `CHK("pad enable", codes[k] != `INSTR_HIGHZ, pad_oe)
         `CHK("pad value", core_out, pad_out)
         ctl.scan(1'h0, 8, 32'hb5, dout);
         `CHK("bypass path", 8'h6a, dout[7:0])
      end
      $display("bypass test done");
   endtask : t_bypass

   task automatic t_sample();
      @(negedge clk);
      pad_in = 4'h5;
      core_out = 4'h9;
      set_ir(`INSTR_SAMPLE);
      ctl.scan(1'h0, 9, {23'h0, 1'h1, 4'h6, 4'h0}, dout);
      `CHK("sampled cells", {1'h1, 4'h9, 4'h5}, dout[8:0])
      repeat (10) @(negedge clk);
      `CHK("preload pins", {1'h1, 4'h9}, {pad_oe, pad_out})
      $display("sample test done");
   endtask : t_sample

   // Word 33 waits for room, word 34 is dropped while it waits: word 33 is the last applied
   task automatic t_fifo();
      int n;
      apply_ready = 1'h0;
      for (int k = 1; k <= 34; k++) begin
         ctl.scan(1'h0, 9, {23'h0, 1'h1, 4'(k), 4'h0}, dout);
      end
      repeat (10) @(negedge clk);
      `CHK("words waiting", 1'h1, apply_pending)
      apply_ready = 1'h1;
      n = 0;
      while (apply_pending !== 1'h0 && n < 100) begin
         @(negedge clk);
         n++;
      end
      `CHK("drained", 1'h0, apply_pending)
      set_ir(`INSTR_EXTEST);
      `CHK("extest pins", {1'h1, 4'h1}, {pad_oe, pad_out})
      set_ir(`INSTR_CLAMP);
      `CHK("clamp pins", {1'h1, 4'h1}, {pad_oe, pad_out})
      ctl.scan(1'h0, 2, 32'h1, dout);
      `CHK("clamp path", 2'h2, dout[1:0])
      $display("buffer test done");
   endtask : t_fifo

   initial begin
      reset = 1'h1;
      core_out = 4'h3;
      core_oe = 1'h1;
      pad_in = 4'ha;
      apply_ready = 1'h1;
      repeat (4) @(negedge clk);
      reset = 1'h0;
      ctl.reset_tap();
      t_idcode();
      t_bypass();
      t_sample();
      t_fifo();
      end_sim();
   end

   initial begin
      #50us;
      failures++;
      $display("watchdog expired");
      end_sim();
   end
endmodule : boundary_scan_test_port_tb_top
